/* nand_status_regs.svh */
// offsets, field positions, opcodes and timing counts of the status and protect block
`ifndef NAND_STATUS_REGS_SVH
`define NAND_STATUS_REGS_SVH

// status byte field positions
`define ST_BUSY      0
`define ST_WEL       1
`define ST_EFAIL     2
`define ST_PFAIL     3
`define ST_ECC_LO    4
`define ST_ECC_HI    5
`define ST_LUTF      6
`define ST_RSVD      7
// status-read address selecting this register (upper nibble)
`define SR3_ADDR_HI  4'hc

// instruction codes
`define OP_RESET     8'hff
`define OP_RDSR      8'h0f
`define OP_RDSR_ALT  8'h05
`define OP_WREN      8'h06
`define OP_WRDI      8'h04
`define OP_REMAP     8'ha1
`define OP_JEDEC     8'h9f
`define OP_ERASE     8'hd8
`define OP_PEXEC     8'h10
`define OP_PREAD     8'h13
`define OP_READ      8'h03
`define OP_FREAD     8'h0b

// cumulative ecc codes
`define ECC_CLEAN    2'b00
`define ECC_CORR     2'b01
`define ECC_UNCORR   2'b10
`define ECC_MULTI    2'b11

`define REMAP_LINKS  5'd20
`define PAGE_W       16
`define BLK_LSB      6
`define PROT_ALL_MIN 4'ha

// power-up busy time
`define MCLK_MHZ     50
`define POWERUP_NS   1000
`define POWERUP_CYC  ((`POWERUP_NS * `MCLK_MHZ + 999) / 1000)
`define PWR_CNT_W    8

`endif

/* nand_status_pkg.sv */
// types shared by the status and protect block
package nand_status_pkg;

    typedef enum logic [1:0] {ph_pwrup, ph_ready, ph_run} phase_t;

    typedef enum logic [2:0] {
        op_none, op_page_read, op_program, op_erase, op_remap, op_cont_read
    } op_kind_t;

    typedef struct packed {
        logic [1:0]  sclk_s;
        logic [1:0]  cs_s;
        logic [1:0]  di_s;
        logic        sclk_d;
        logic        cs_d;
        logic [2:0]  bitc;
        logic [2:0]  nbyte;
        logic [7:0]  rx;
        logic [7:0]  opcode;
        logic [15:0] addr;
        logic        ignored;
        logic        sr_sel;
        logic [7:0]  tx;
        logic        do_q;
        logic        do_oe_n;
        phase_t      phase;
        logic [7:0]  pwr_cnt;
        op_kind_t    run_kind;
        logic        write_enable_latch;
        logic        efail;
        logic        pfail;
        logic [1:0]  ecc;
        logic [4:0]  links;
        logic        op_start;
        op_kind_t    op_kind;
        logic [15:0] op_page;
    } state_t;

endpackage

/* protect_range_decode.sv */
// decodes top/bottom and block-protect size into a hit on one page address
`include "nand_status_regs.svh"
module protect_range_decode #(
    parameter int page_w  = `PAGE_W,
    parameter int blk_lsb = `BLK_LSB
) (
    input  wire logic              top_bottom_select, // 1 protects the bottom end
    input  wire logic [3:0]        protect_size,      // protect size code
    input  wire logic [page_w-1:0] page_address,      // page to check
    output logic                   protected_hit      // page lies in protected area
);
    localparam int blk_w = page_w - blk_lsb;
    localparam logic [blk_w:0] one = (blk_w + 1)'(1);

    logic [blk_w:0] blk;
    logic [blk_w:0] span;

    always_comb begin
        blk = {1'b0, page_address[page_w-1:blk_lsb]};
        span = one << protect_size;
        if (protect_size == 4'h0) begin
            protected_hit = 1'b0;
        end else if (protect_size >= `PROT_ALL_MIN) begin
            protected_hit = 1'b1;
        end else if (top_bottom_select) begin
            protected_hit = blk < span;
        end else begin
            protected_hit = blk >= ((one << blk_w) - span);
        end
    end
endmodule

/* nand_status_and_block_protect.sv */
// status flags, instruction gating and array protect of one serial nand die
// Operation
// - twenty remap links, full flag blocks more
// - code 00 when no correction needed
// - code 01 when 1-4 bits corrected
// - code 10 for one uncorrectable page
// - code 11 only in continuous read
// - ecc bits cleared by reset command
// - fail flags set on failure or protection
// - fail flags cleared at program/erase/reset
// - write-enable instruction sets the latch
// - latch cleared by disable, program, erase, page read
// - busy during power-up and internal operations
// - busy ignores all but status, id reads
// - busy clears when operation completes
// - reserved bits ignored, read as zero
// - size codes protect doubling block span
// - codes 101x, 11xx protect everything
// - program/erase on protected area ignored
// - buffer bit selects buffer or continuous
`include "nand_status_regs.svh"
module nand_status_and_block_protect
    import nand_status_pkg::*;
#(
    parameter logic [7:0]  mfr_id = 8'h5a,    // arbitrary value
    parameter logic [15:0] dev_id = 16'h1234  // arbitrary value
) (
    input  wire logic        mclk,              // block clock
    input  wire logic        nrst,              // async reset, active low
    input  wire logic        spi_sclk,          // serial clock from host
    input  wire logic        spi_cs_n,          // chip select, active low
    input  wire logic        spi_di,            // serial data in
    output logic             spi_do,            // serial data out
    output logic             spi_do_oe_n,       // data out enable, active low
    input  wire logic        op_done,           // array engine finished
    input  wire logic        op_fail,           // finished operation failed
    input  wire logic        ecc_page_done,     // one page checked by ecc
    input  wire logic [1:0]  ecc_page_class,    // clean, corrected, uncorrectable
    input  wire logic        ecc_enable,        // ecc engine on
    input  wire logic        buf_mode,          // 1 buffer read, 0 continuous
    input  wire logic        otp_access,        // commands target otp area
    input  wire logic        otp_locked,        // otp area locked
    input  wire logic        top_bottom_select, // protect bottom end when 1
    input  wire logic        protect_size_bit3, // protect size code bit 3
    input  wire logic        protect_size_bit2, // protect size code bit 2
    input  wire logic        protect_size_bit1, // protect size code bit 1
    input  wire logic        protect_size_bit0, // protect size code bit 0
    output logic             op_start,          // start pulse to array engine
    output op_kind_t         op_kind,           // operation to run
    output logic [15:0]      op_page            // page address of operation
);
    state_t      st;
    state_t      next_st;
    logic        busy;
    logic        lutf;
    logic        hit;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        cs_rise;
    logic        frame_ok;
    logic        read_ok;
    logic        exec_reset;
    logic        exec_wren;
    logic        prot_attempt;
    logic        byte0_done;
    logic        sel;
    logic [7:0]  status;
    logic [7:0]  rx_nx;

    protect_range_decode #(
        .page_w  (`PAGE_W),
        .blk_lsb (`BLK_LSB)
    ) u_protect (
        .top_bottom_select (top_bottom_select),
        .protect_size      ({protect_size_bit3, protect_size_bit2,
                             protect_size_bit1, protect_size_bit0}),
        .page_address      (st.addr),
        .protected_hit     (hit)
    );

    assign busy       = st.phase != ph_ready;
    assign lutf       = st.links == `REMAP_LINKS;
    assign sclk_rise  = st.sclk_s[1] & ~st.sclk_d;
    assign sclk_fall  = ~st.sclk_s[1] & st.sclk_d;
    assign cs_fall    = ~st.cs_s[1] & st.cs_d;
    assign cs_rise    = st.cs_s[1] & ~st.cs_d;
    // write-type commands act only on a byte boundary
    assign frame_ok   = cs_rise && !st.ignored && st.bitc == 3'd0 && st.nbyte != 3'd0;
    assign rx_nx      = {st.rx[6:0], st.di_s[1]};
    assign byte0_done = !st.cs_s[1] && sclk_rise && st.bitc == 3'd7 && st.nbyte == 3'd0;
    assign read_ok    = rx_nx == `OP_RDSR || rx_nx == `OP_RDSR_ALT || rx_nx == `OP_JEDEC;
    assign exec_reset = frame_ok && st.opcode == `OP_RESET;
    assign exec_wren  = frame_ok && st.opcode == `OP_WREN;
    assign prot_attempt = frame_ok && st.opcode == `OP_PEXEC && st.nbyte >= 3'd4
                          && st.write_enable_latch && (hit || (otp_access && otp_locked));

    always_comb begin
        status = 8'h00;
        status[`ST_BUSY]   = busy;
        status[`ST_WEL]    = st.write_enable_latch;
        status[`ST_EFAIL]  = st.efail;
        status[`ST_PFAIL]  = st.pfail;
        status[`ST_ECC_LO] = st.ecc[0];
        status[`ST_ECC_HI] = st.ecc[1];
        status[`ST_LUTF]   = lutf;
        status[`ST_RSVD]   = 1'b0;
    end

    always_comb begin
        next_st = st;
        sel = st.sr_sel;
        next_st.sclk_s = {st.sclk_s[0], spi_sclk};
        next_st.cs_s = {st.cs_s[0], spi_cs_n};
        next_st.di_s = {st.di_s[0], spi_di};
        next_st.sclk_d = st.sclk_s[1];
        next_st.cs_d = st.cs_s[1];
        next_st.op_start = 1'b0;
        if (cs_fall) begin
            next_st.bitc = 3'd0;
            next_st.nbyte = 3'd0;
            next_st.ignored = 1'b0;
            next_st.tx = 8'h00;
        end
        if (!st.cs_s[1] && sclk_rise) begin
            next_st.rx = rx_nx;
            next_st.bitc = st.bitc + 3'd1;
            if (st.bitc == 3'd7) begin
                if (st.nbyte != 3'd7) begin
                    next_st.nbyte = st.nbyte + 3'd1;
                end
                if (st.nbyte == 3'd0) begin
                    next_st.opcode = rx_nx;
                    if (busy && !read_ok) begin
                        next_st.ignored = 1'b1;
                    end
                end else begin
                    next_st.addr = {st.addr[7:0], rx_nx};
                end
                // status bytes repeat live for as long as the host clocks
                if (st.nbyte != 3'd0 && (st.opcode == `OP_RDSR || st.opcode == `OP_RDSR_ALT)) begin
                    if (st.nbyte == 3'd1) begin
                        sel = rx_nx[7:4] == `SR3_ADDR_HI;
                    end
                    next_st.sr_sel = sel;
                    next_st.tx = sel ? status : 8'h00;
                    next_st.do_oe_n = 1'b0;
                end
                if (st.nbyte != 3'd0 && st.opcode == `OP_JEDEC) begin
                    case (st.nbyte)
                        3'd1: next_st.tx = mfr_id;
                        3'd2: next_st.tx = dev_id[15:8];
                        3'd3: next_st.tx = dev_id[7:0];
                        default: next_st.tx = 8'h00;
                    endcase
                    next_st.do_oe_n = 1'b0;
                end
            end
        end
        if (!st.cs_s[1] && sclk_fall) begin
            next_st.do_q = st.tx[7];
            next_st.tx = {st.tx[6:0], 1'b0};
        end
        if (cs_rise) begin
            next_st.do_oe_n = 1'b1;
        end
        if (frame_ok) begin
            case (st.opcode)
                `OP_WREN: next_st.write_enable_latch = 1'b1;
                `OP_WRDI: next_st.write_enable_latch = 1'b0;
                `OP_RESET: begin
                    next_st.ecc = `ECC_CLEAN;
                    next_st.pfail = 1'b0;
                    next_st.efail = 1'b0;
                end
                `OP_PEXEC, `OP_ERASE: begin
                    if (st.nbyte >= 3'd4) begin
                        next_st.pfail = 1'b0;
                        next_st.efail = 1'b0;
                        next_st.write_enable_latch = 1'b0;
                        if (st.write_enable_latch) begin
                            if (st.opcode == `OP_PEXEC && (hit || (otp_access && otp_locked))) begin
                                next_st.pfail = 1'b1;
                            end else if (st.opcode == `OP_ERASE && (hit || otp_access)) begin
                                next_st.efail = 1'b1;
                            end else begin
                                next_st.op_start = 1'b1;
                                next_st.op_kind = st.opcode == `OP_PEXEC ? op_program : op_erase;
                            end
                        end
                    end
                end
                `OP_PREAD: begin
                    if (st.nbyte >= 3'd4) begin
                        next_st.write_enable_latch = 1'b0;
                        next_st.ecc = `ECC_CLEAN;
                        next_st.op_start = 1'b1;
                        next_st.op_kind = op_page_read;
                    end
                end
                `OP_REMAP: begin
                    if (st.nbyte >= 3'd5 && !lutf) begin
                        next_st.op_start = 1'b1;
                        next_st.op_kind = op_remap;
                    end
                end
                `OP_READ, `OP_FREAD: begin
                    if (!buf_mode) begin
                        next_st.ecc = `ECC_CLEAN;
                        next_st.op_start = 1'b1;
                        next_st.op_kind = op_cont_read;
                    end
                end
                default: ;
            endcase
        end
        if (next_st.op_start) begin
            next_st.op_page = st.addr;
            next_st.run_kind = next_st.op_kind;
            next_st.phase = ph_run;
        end
        case (st.phase)
            ph_pwrup: begin
                if (st.pwr_cnt == `PWR_CNT_W'(`POWERUP_CYC - 1)) begin
                    next_st.phase = ph_ready;
                end else begin
                    next_st.pwr_cnt = st.pwr_cnt + `PWR_CNT_W'(1);
                end
            end
            ph_run: begin
                if (op_done) begin
                    next_st.phase = ph_ready;
                    if (op_fail && st.run_kind == op_program) begin
                        next_st.pfail = 1'b1;
                    end
                    if (op_fail && st.run_kind == op_erase) begin
                        next_st.efail = 1'b1;
                    end
                    if (!op_fail && st.run_kind == op_remap && !lutf) begin
                        next_st.links = st.links + 5'd1;
                    end
                end
            end
            ph_ready: ;
            default: next_st.phase = ph_ready;
        endcase
        // events come last so a set wins over a clear in the same cycle
        if (ecc_page_done && ecc_enable) begin
            case (ecc_page_class)
                `ECC_CORR: if (st.ecc == `ECC_CLEAN) next_st.ecc = `ECC_CORR;
                `ECC_UNCORR: begin
                    if (st.ecc[1] && !buf_mode && st.run_kind == op_cont_read) begin
                        next_st.ecc = `ECC_MULTI;
                    end else if (st.ecc != `ECC_MULTI) begin
                        next_st.ecc = `ECC_UNCORR;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.cs_s <= 2'b11;
            st.cs_d <= 1'b1;
            st.do_oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign spi_do      = st.do_q;
    assign spi_do_oe_n = st.do_oe_n;
    assign op_start    = st.op_start;
    assign op_kind     = st.op_kind;
    assign op_page     = st.op_page;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_prog_start;
        st.op_start && (st.op_kind == op_program || st.op_kind == op_erase);
    endsequence

    sequence s_done;
        st.phase == ph_run && op_done;
    endsequence

    property p_lutf_cap;
        lutf |=> !(st.op_start && st.op_kind == op_remap) && st.links == `REMAP_LINKS;
    endproperty
    a_lutf_cap: assert property (p_lutf_cap) else $error("remap after table full");

    property p_ecc_clean_start;
        st.op_start && st.op_kind == op_page_read |-> st.ecc == `ECC_CLEAN;
    endproperty
    a_ecc_clean_start: assert property (p_ecc_clean_start) else $error("ecc not clean");

    property p_ecc_corr;
        ecc_page_done && ecc_enable && ecc_page_class == `ECC_CORR && st.ecc == `ECC_CLEAN
        |=> st.ecc == `ECC_CORR;
    endproperty
    a_ecc_corr: assert property (p_ecc_corr) else $error("corrected code missing");

    property p_ecc_uncorr;
        ecc_page_done && ecc_enable && ecc_page_class == `ECC_UNCORR && !st.ecc[1]
        |=> st.ecc == `ECC_UNCORR;
    endproperty
    a_ecc_uncorr: assert property (p_ecc_uncorr) else $error("uncorrectable code missing");

    property p_ecc_multi;
        $rose(st.ecc == `ECC_MULTI) |-> !$past(buf_mode) && st.run_kind == op_cont_read;
    endproperty
    a_ecc_multi: assert property (p_ecc_multi) else $error("multi code outside continuous");

    property p_ecc_reset;
        exec_reset && !ecc_page_done |=> st.ecc == `ECC_CLEAN;
    endproperty
    a_ecc_reset: assert property (p_ecc_reset) else $error("reset left ecc bits");

    property p_prot_fail;
        prot_attempt |=> st.pfail && !st.op_start;
    endproperty
    a_prot_fail: assert property (p_prot_fail) else $error("protected program not flagged");

    property p_fail_clear;
        s_prog_start |-> !st.pfail && !st.efail && !st.write_enable_latch;
    endproperty
    a_fail_clear: assert property (p_fail_clear) else $error("flags not cleared at start");

    property p_wren;
        exec_wren |=> st.write_enable_latch;
    endproperty
    a_wren: assert property (p_wren) else $error("latch not set");

    property p_busy_start;
        st.op_start |-> busy ##1 (busy || $past(op_done));
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy missing at start");

    property p_gate;
        byte0_done && busy && !read_ok |=> st.ignored ##1 !st.op_start;
    endproperty
    a_gate: assert property (p_gate) else $error("busy did not gate");

    property p_done;
        s_done |=> !busy;
    endproperty
    a_done: assert property (p_done) else $error("busy stuck after done");

    property p_protect;
        s_prog_start |-> !$past(hit);
    endproperty
    a_protect: assert property (p_protect) else $error("protected area started");
endmodule

/* spi_host_model.sv */
// serial host model that clocks whole command frames in mode 0
module spi_host_model (
    input  wire logic mclk,        // block clock, paces the serial clock
    input  wire logic spi_do,      // data from the device
    input  wire logic spi_do_oe_n, // device drive enable, active low
    output logic      spi_sclk,    // serial clock, still outside frames
    output logic      spi_cs_n,    // chip select, active low
    output logic      spi_di       // serial data to the device
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_di   = 1'b0;
    end

    // one bit per 8 mclk; the bits read back are the last ones of rx
    task automatic frame(input logic [39:0] tx, input int n, output logic [39:0] rx);
        rx = '0;
        @(posedge mclk);
        #2 spi_cs_n = 1'b0;
        for (int i = 0; i < n * 8; i++) begin
            spi_di = tx[n*8-1-i];
            repeat (4) @(posedge mclk);
            #2 spi_sclk = 1'b1;
            // a released line must not pass for a valid bit
            rx = {rx[38:0], (spi_do_oe_n === 1'b0) ? spi_do : 1'bx};
            repeat (4) @(posedge mclk);
            #2 spi_sclk = 1'b0;
        end
        repeat (4) @(posedge mclk);
        #2 spi_cs_n = 1'b1;
        // idle data line shows the inverse of its last bit
        spi_di = ~spi_di;
        repeat (8) @(posedge mclk);
        // return off the edge so that callers never change inputs as the design samples them
        #2;
    endtask
endmodule

/* nand_status_and_block_protect_tb_top.sv */
// self-checking bench of the status and protect block
module nand_status_and_block_protect_tb_top
    import nand_status_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    logic       mclk = 1'b0, nrst = 1'b0, spi_sclk, spi_cs_n, spi_di, spi_do, spi_do_oe_n;
    logic       op_done = 1'b0, op_fail = 1'b0, ecc_page_done = 1'b0, fail_next = 1'b0;
    logic       ecc_enable = 1'b1, buf_mode = 1'b1, otp_access = 1'b0, otp_locked = 1'b0;
    logic       top_bottom_select = 1'b0, op_start;
    logic [1:0] ecc_page_class = 2'b00;
    logic [1:0] ecc_cls [2];
    logic [3:0] psize = 4'h0;
    logic [15:0] op_page;
    op_kind_t   op_kind;
    int         n_errors = 0, total_checks = 0, n_start = 0, eng_wait = 10, n_ecc = 0, cyc = 0, k;
    // arbitrary id values handed to the design, so the id read has a known answer
    localparam logic [7:0]  id_mfr = 8'h3c;
    localparam logic [15:0] id_dev = 16'h5e71;
    logic [39:0] id_rx;

    typedef struct {logic [7:0] op; logic otp; logic bot; logic [3:0] sz;
                    logic [15:0] page; logic prot;} prot_row_t;
    typedef struct {logic en; logic bm; logic [7:0] op; int n; logic [1:0] c0;
                    logic [1:0] c1; logic [1:0] code;} ecc_row_t;
    prot_row_t prot_rows [14] = '{
        '{8'hd8,0,0,4'h1,16'hff80,1}, '{8'h10,0,0,4'h1,16'hff7f,0}, '{8'hd8,0,1,4'h1,16'h007f,1},
        '{8'h10,0,1,4'h1,16'h0080,0}, '{8'h10,0,0,4'h9,16'h8000,1}, '{8'hd8,0,0,4'h9,16'h7fff,0},
        '{8'hd8,0,1,4'h9,16'h7fff,1}, '{8'h10,0,1,4'h9,16'h8000,0}, '{8'hd8,0,0,4'h5,16'hf800,1},
        '{8'hd8,0,1,4'ha,16'hffff,1}, '{8'h10,0,0,4'hc,16'h0000,1}, '{8'hd8,0,1,4'hf,16'h1234,1},
        '{8'h10,1,0,4'h0,16'h0040,1}, '{8'hd8,0,0,4'h0,16'hffff,0}};
    ecc_row_t ecc_rows [7] = '{
        '{1,1,8'h13,1,2'b00,2'b00,2'b00}, '{1,1,8'h13,1,2'b01,2'b00,2'b01},
        '{1,1,8'h13,1,2'b10,2'b00,2'b10}, '{1,1,8'h13,2,2'b10,2'b10,2'b10},
        '{0,1,8'h13,1,2'b10,2'b00,2'b00}, '{1,0,8'h03,2,2'b01,2'b00,2'b01},
        '{1,0,8'h0b,2,2'b10,2'b10,2'b11}};

    nand_status_and_block_protect #(.mfr_id(id_mfr), .dev_id(id_dev))
        nand_status_and_block_protect_i (
        .mclk(mclk), .nrst(nrst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_di(spi_di),
        .spi_do(spi_do), .spi_do_oe_n(spi_do_oe_n), .op_done(op_done), .op_fail(op_fail),
        .ecc_page_done(ecc_page_done), .ecc_page_class(ecc_page_class),
        .ecc_enable(ecc_enable), .buf_mode(buf_mode), .otp_access(otp_access),
        .otp_locked(otp_locked), .top_bottom_select(top_bottom_select),
        .protect_size_bit3(psize[3]), .protect_size_bit2(psize[2]),
        .protect_size_bit1(psize[1]), .protect_size_bit0(psize[0]),
        .op_start(op_start), .op_kind(op_kind), .op_page(op_page));
    spi_host_model spi_host_model_i (.mclk(mclk), .spi_do(spi_do), .spi_do_oe_n(spi_do_oe_n),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_di(spi_di));

    always #10 mclk = ~mclk;

    // array engine: ecc pages first, then a done pulse after a set wait
    always begin
        @(posedge mclk);
        #1;
        if (op_start === 1'b1) begin
            n_start++;
            for (int i = 0; i < n_ecc; i++) begin
                @(posedge mclk);
                #2 ecc_page_done = 1'b1;
                ecc_page_class = ecc_cls[i];
                @(posedge mclk);
                #2 ecc_page_done = 1'b0;
            end
            repeat (eng_wait) @(posedge mclk);
            #2 op_done = 1'b1;
            op_fail = fail_next;
            @(posedge mclk);
            #2 op_done = 1'b0;
            op_fail = 1'b0;
        end
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 90000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmd(input logic [39:0] tx, input int n);
        logic [39:0] rx;
        spi_host_model_i.frame(tx, n, rx);
    endtask

    // the reserved top bit is left out of every status compare
    task automatic status(output logic [6:0] s);
        logic [39:0] rx;
        spi_host_model_i.frame(40'h0fc000, 3, rx);
        s = rx[6:0];
    endtask

    task automatic chk_st(input string what, input logic [6:0] exp);
        logic [6:0] s;
        status(s);
        chk(what, 40'(exp), 40'(s));
    endtask

    task automatic idle();
        logic [6:0] s;
        s = 7'h01;
        for (int i = 0; i < 12 && s[0] !== 1'b0; i++) status(s);
        chk("busy", 40'h0, 40'(s[0]));
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        #2 nrst = 1'b1;
        repeat (60) @(posedge mclk);
        chk_st("status after reset", 7'h00);
        foreach (ecc_rows[r]) begin
            {ecc_enable, buf_mode, n_ecc} = {ecc_rows[r].en, ecc_rows[r].bm, ecc_rows[r].n};
            ecc_cls = '{ecc_rows[r].c0, ecc_rows[r].c1};
            cmd({8'h00, ecc_rows[r].op, 24'h000100}, 4);
            idle();
            chk("kind", 40'(ecc_rows[r].bm ? op_page_read : op_cont_read), 40'(op_kind));
            chk_st("ecc code", {1'b0, ecc_rows[r].code, 4'h0});
        end
        {n_ecc, buf_mode, fail_next} = {32'd0, 1'b1, 1'b1};
        cmd(40'h06, 1);
        cmd(40'hd8000040, 4);
        idle();
        fail_next = 1'b0;
        chk_st("erase fail", 7'h34);
        cmd(40'hff, 1);
        chk_st("after reset cmd", 7'h00);
        $display("ecc and fail tests done");
        foreach (prot_rows[r]) begin
            {otp_access, otp_locked} = {2{prot_rows[r].otp}};
            {top_bottom_select, psize} = {prot_rows[r].bot, prot_rows[r].sz};
            k = n_start;
            cmd(40'h06, 1);
            cmd({8'h00, prot_rows[r].op, 8'h00, prot_rows[r].page}, 4);
            if (!prot_rows[r].prot) idle();
            chk_st("fail flags", {3'b000, prot_rows[r].prot && prot_rows[r].op == 8'h10,
                prot_rows[r].prot && prot_rows[r].op == 8'hd8, 2'b00});
            chk("started", 40'(!prot_rows[r].prot), 40'(n_start - k));
            if (!prot_rows[r].prot) chk("page", 40'(prot_rows[r].page), 40'(op_page));
        end
        $display("protect table done");
        cmd(40'h06, 1);
        chk_st("latch set", 7'h02);
        cmd(40'h04, 1);
        chk_st("latch clear", 7'h00);
        // long enough for the ignored write, two status reads and the start of the id read while busy
        eng_wait = 800;
        cmd(40'h06, 1);
        cmd(40'hd8000040, 4);
        cmd(40'h06, 1);
        chk_st("busy ignores", 7'h01);
        spi_host_model_i.frame(40'h05c000, 3, id_rx);
        chk("alt status", 40'h01, 40'(id_rx[6:0]));
        spi_host_model_i.frame(40'h9f00000000, 5, id_rx);
        chk("id", 40'({id_mfr, id_dev}), 40'(id_rx[23:0]));
        idle();
        chk_st("still no latch", 7'h00);
        eng_wait = 10;
        $display("latch and busy tests done");
        k = n_start;
        for (int i = 0; i < 21; i++) begin
            logic [6:0] s;
            cmd(40'h06, 1);
            cmd({8'ha1, 32'(i)}, 5);
            if (i < 20) idle();
            status(s);
            chk("table full", 40'(i >= 19), 40'(s[6]));
        end
        chk("remaps started", 40'd20, 40'(n_start - k));
        cmd(40'h06, 1);
        nrst = 1'b0;
        repeat (2) @(posedge mclk);
        #2 nrst = 1'b1;
        repeat (60) @(posedge mclk);
        chk_st("second reset", 7'h00);
        $display("remap and reset tests done");
        close_out();
    end
endmodule
